// *** include/asb_pkg.sv ***
/*
 Shared constants and types of the break/idle capable asynchronous serial unit.
 Assumes a single clock domain and a synchronous active-high reset.
*/
package asb_pkg;
  // last sub-bit sample index of a bit period (16 samples per bit)
  localparam logic [3:0] OVS_LAST = 4'hf;
  // the three samples voted on around the bit centre
  localparam logic [3:0] SAMP_A = 4'h7;
  localparam logic [3:0] SAMP_B = 4'h8;
  localparam logic [3:0] SAMP_C = 4'h9;
  // bits per frame: start + data + one stop
  localparam logic [3:0] FRAME8 = 4'ha;
  localparam logic [3:0] FRAME9 = 4'hb;
  // data bits per word
  localparam logic [3:0] DATA8 = 4'h8;
  localparam logic [3:0] DATA9 = 4'h9;
  // reset values
  localparam logic [10:0] TX_SHIFT_RST = 11'h7ff;
  localparam logic [8:0] WORD_RST = 9'h000;
  localparam logic [7:0] PRE_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [1:0] VOTE_RST = 2'h0;
  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP} asb_rx_state_t;
endpackage : asb_pkg

// *** verilog/asb_serial.sv ***
/*
 Asynchronous serial unit: transmitter with break and idle frame generation,
 receiver for 8/9-bit words with holding buffer, error flags and interrupt.
 Assumes control bits arrive as plain levels from CPU logic on clk_i, reads of
 the status and data port arrive as one-cycle pulses, and rx_in_pin_i is async.
*/
`timescale 1ns/100ps
module asb_serial (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic word9_i,
  input wire logic [7:0] baud_select_reg_i,
  input wire logic [7:0] extended_rx_baud_reg_i,
  input wire logic tx_on_i,
  input wire logic break_send_request_i,
  input wire logic tx_wr_i,
  input wire logic [8:0] tx_data_i,
  output logic tx_holding_empty_o,
  output logic txd_o,
  input wire logic rx_on_i,
  input wire logic rx_in_pin_i,
  input wire logic status_rd_i,
  input wire logic data_rd_i,
  output logic [7:0] rx_data_o,
  output logic ninth_rx_bit_o,
  output logic rx_holding_full_o,
  output logic idle_flag_o,
  output logic overrun_o,
  output logic noise_o,
  output logic framing_o,
  input wire logic rx_irq_enable_i,
  input wire logic idle_irq_enable_i,
  input wire logic cpu_irq_mask_i,
  output logic irq_o
);
  import asb_pkg::*;

  logic [3:0] flen;
  logic [3:0] nbits;
  assign flen = word9_i ? FRAME9 : FRAME8;
  assign nbits = word9_i ? DATA9 : DATA8;

  // transmitter
  logic [10:0] tx_sh, next_tx_sh;
  logic [3:0] tx_left, next_tx_left;
  logic [3:0] tx_sub, next_tx_sub;
  logic [7:0] tx_pre, next_tx_pre;
  logic [8:0] tx_holding_buffer, next_tx_holding_buffer;
  logic hold_v, next_hold_v;
  logic idle_pend, next_idle_pend;
  logic brk_tail, next_brk_tail;
  logic tx_on_d, next_tx_on_d;
  logic tx_tick, tx_bit_end, tx_load;

  assign tx_tick = (tx_pre == baud_select_reg_i);
  assign tx_bit_end = tx_tick && (tx_sub == OVS_LAST);
  // a new frame is chosen only at a bit boundary once the last bit is out
  assign tx_load = tx_bit_end && (tx_left <= 4'h1);

  always_comb begin
    next_tx_sh = tx_sh;
    next_tx_left = tx_left;
    next_tx_pre = tx_tick ? PRE_RST : tx_pre + 8'h01;
    next_tx_sub = tx_tick ? tx_sub + 4'h1 : tx_sub;
    next_tx_holding_buffer = tx_holding_buffer;
    next_hold_v = hold_v;
    next_idle_pend = idle_pend;
    next_brk_tail = brk_tail;
    next_tx_on_d = tx_on_i;
    if (tx_wr_i && !hold_v) begin
      next_tx_holding_buffer = tx_data_i;
      next_hold_v = 1'b1;
    end
    if (tx_on_i && !tx_on_d) begin
      next_hold_v = 1'b0;
      next_idle_pend = 1'b1;
    end
    if (tx_bit_end && tx_left > 4'h1) begin
      next_tx_sh = {1'b1, tx_sh[10:1]};
      next_tx_left = tx_left - 4'h1;
    end else if (tx_load) begin
      next_tx_sh = TX_SHIFT_RST;
      next_tx_left = CNT_RST;
      if (tx_on_i) begin
        if (break_send_request_i) begin
          next_tx_sh = '0;
          next_tx_left = flen;
          next_brk_tail = 1'b1;
        end else if (brk_tail) begin
          next_tx_left = 4'h1;
          next_brk_tail = 1'b0;
        end else if (idle_pend || !tx_on_d) begin // re-enable during a load sends idle first
          next_tx_left = flen;
          next_idle_pend = 1'b0;
        end else if (hold_v) begin
          next_tx_sh = word9_i ? {1'b1, tx_holding_buffer, 1'b0}
                               : {2'b11, tx_holding_buffer[7:0], 1'b0};
          next_tx_left = flen;
          next_hold_v = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_sh <= TX_SHIFT_RST;
      tx_left <= CNT_RST;
      tx_sub <= CNT_RST;
      tx_pre <= PRE_RST;
      tx_holding_buffer <= WORD_RST;
      hold_v <= 1'b0;
      idle_pend <= 1'b0;
      brk_tail <= 1'b0;
      tx_on_d <= 1'b0;
    end else begin
      tx_sh <= next_tx_sh;
      tx_left <= next_tx_left;
      tx_sub <= next_tx_sub;
      tx_pre <= next_tx_pre;
      tx_holding_buffer <= next_tx_holding_buffer;
      hold_v <= next_hold_v;
      idle_pend <= next_idle_pend;
      brk_tail <= next_brk_tail;
      tx_on_d <= next_tx_on_d;
    end
  end

  assign txd_o = tx_sh[0];
  assign tx_holding_empty_o = !hold_v;

  // receiver
  logic rx_s1, rx_s2, rx_s3;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
    end else begin
      rx_s1 <= rx_in_pin_i;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end

  asb_rx_state_t rx_st, next_rx_st;
  logic [7:0] rx_pre, next_rx_pre;
  logic [3:0] rx_sub, next_rx_sub;
  logic [3:0] rx_cnt, next_rx_cnt;
  logic [1:0] votes, next_votes;
  logic [8:0] rx_sh, next_rx_sh;
  logic [8:0] rx_holding_buffer, next_rx_holding_buffer;
  logic noise_acc, next_noise_acc;
  logic full, next_full;
  logic ovr, next_ovr;
  logic fe, next_fe;
  logic nf, next_nf;
  logic idle_f, next_idle_f;
  logic idle_armed, next_idle_armed;
  logic [3:0] idle_cnt, next_idle_cnt;
  logic rd_armed, next_rd_armed;
  logic [7:0] rx_div;
  logic rx_tick, rx_bit_end, maj, bit_noise, rx_done;
  logic [8:0] word;

  // the extended prescaler, when nonzero, overrides the common one
  assign rx_div = (extended_rx_baud_reg_i != PRE_RST) ? extended_rx_baud_reg_i
                                                      : baud_select_reg_i;
  assign rx_tick = (rx_pre == rx_div);
  assign rx_bit_end = rx_tick && (rx_sub == OVS_LAST);
  assign maj = votes[1];
  assign bit_noise = (votes == 2'h1) || (votes == 2'h2);
  assign rx_done = (rx_st == RX_STOP) && rx_bit_end;
  assign word = word9_i ? rx_sh : {1'b0, rx_sh[8:1]};

  always_comb begin
    next_rx_st = rx_st;
    next_rx_pre = rx_tick ? PRE_RST : rx_pre + 8'h01;
    next_rx_sub = rx_tick ? rx_sub + 4'h1 : rx_sub;
    next_rx_cnt = rx_cnt;
    next_votes = votes;
    next_rx_sh = rx_sh;
    next_rx_holding_buffer = rx_holding_buffer;
    next_noise_acc = noise_acc;
    next_full = full;
    next_ovr = ovr;
    next_fe = fe;
    next_nf = nf;
    next_idle_f = idle_f;
    next_idle_armed = idle_armed;
    next_idle_cnt = idle_cnt;
    next_rd_armed = rd_armed;
    // clearing first so that a same-cycle set below wins
    if (status_rd_i) begin
      next_rd_armed = 1'b1;
    end else if (data_rd_i && rd_armed) begin
      next_full = 1'b0;
      next_ovr = 1'b0;
      next_fe = 1'b0;
      next_nf = 1'b0;
      next_idle_f = 1'b0;
      next_rd_armed = 1'b0;
    end
    if (rx_tick && (rx_sub == SAMP_A || rx_sub == SAMP_B || rx_sub == SAMP_C)) begin
      next_votes = votes + {1'b0, rx_s2};
    end
    if (rx_bit_end) begin
      next_votes = VOTE_RST;
    end
    unique case (rx_st)
      RX_HUNT: begin
        if (rx_bit_end) begin
          next_idle_cnt = maj ? idle_cnt + 4'h1 : CNT_RST;
          if (maj && idle_armed && idle_cnt + 4'h1 == flen) begin
            next_idle_f = 1'b1;
            next_idle_armed = 1'b0;
          end
        end
        if (rx_on_i && rx_s3 && !rx_s2) begin
          next_rx_st = RX_START;
          next_rx_pre = PRE_RST;
          next_rx_sub = CNT_RST;
          next_votes = VOTE_RST;
          next_noise_acc = 1'b0;
        end
      end
      RX_START: begin
        if (rx_bit_end) begin
          next_noise_acc = bit_noise;
          next_rx_cnt = CNT_RST;
          next_rx_st = maj ? RX_HUNT : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_bit_end) begin
          next_rx_sh = {maj, rx_sh[8:1]};
          next_noise_acc = noise_acc | bit_noise;
          next_rx_cnt = rx_cnt + 4'h1;
          if (rx_cnt + 4'h1 == nbits) begin
            next_rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_bit_end) begin
          next_rx_st = RX_HUNT;
          next_idle_armed = 1'b1;
          next_idle_cnt = CNT_RST;
          if (full) begin
            next_ovr = 1'b1;
          end else begin
            next_rx_holding_buffer = word;
            next_full = 1'b1;
            next_fe = !maj;
            next_nf = noise_acc | bit_noise;
          end
        end
      end
    endcase
    if (!rx_on_i) begin
      next_rx_st = RX_HUNT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st <= RX_HUNT;
      rx_pre <= PRE_RST;
      rx_sub <= CNT_RST;
      rx_cnt <= CNT_RST;
      votes <= VOTE_RST;
      rx_sh <= WORD_RST;
      rx_holding_buffer <= WORD_RST;
      noise_acc <= 1'b0;
      full <= 1'b0;
      ovr <= 1'b0;
      fe <= 1'b0;
      nf <= 1'b0;
      idle_f <= 1'b0;
      idle_armed <= 1'b0;
      idle_cnt <= CNT_RST;
      rd_armed <= 1'b0;
    end else begin
      rx_st <= next_rx_st;
      rx_pre <= next_rx_pre;
      rx_sub <= next_rx_sub;
      rx_cnt <= next_rx_cnt;
      votes <= next_votes;
      rx_sh <= next_rx_sh;
      rx_holding_buffer <= next_rx_holding_buffer;
      noise_acc <= next_noise_acc;
      full <= next_full;
      ovr <= next_ovr;
      fe <= next_fe;
      nf <= next_nf;
      idle_f <= next_idle_f;
      idle_armed <= next_idle_armed;
      idle_cnt <= next_idle_cnt;
      rd_armed <= next_rd_armed;
    end
  end

  assign rx_data_o = rx_holding_buffer[7:0];
  assign ninth_rx_bit_o = rx_holding_buffer[8];
  assign rx_holding_full_o = full;
  assign idle_flag_o = idle_f;
  assign overrun_o = ovr;
  assign noise_o = nf;
  assign framing_o = fe;
  assign irq_o = !cpu_irq_mask_i && ((rx_irq_enable_i && (full || ovr)) ||
                 (idle_irq_enable_i && idle_f));

  AST_BRK_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_load && tx_on_i && break_send_request_i) |=> (!txd_o && tx_sh == 11'h000))
    else $error("break frame not loaded");
  AST_BRK_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_load && tx_on_i && break_send_request_i) |=>
    (tx_left == ($past(word9_i) ? FRAME9 : FRAME8)))
    else $error("break frame length wrong");
  AST_BRK_TAIL: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_load && tx_on_i && !break_send_request_i && brk_tail) |=>
    (txd_o && tx_left == 4'h1 && !brk_tail))
    else $error("no high bit after break");
  AST_TX_REEN: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(tx_on_i) |=> (!hold_v && (idle_pend || tx_sh == TX_SHIFT_RST)))
    else $error("re-enable did not queue idle or drop holding data");
  AST_IDLE_FRAME: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_load && tx_on_i && !break_send_request_i && !brk_tail && idle_pend) |=>
    (tx_sh == TX_SHIFT_RST && tx_left == $past(flen) && !idle_pend))
    else $error("idle frame not sent");
  AST_RX_FILL: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_done && !full) |=> (full && rx_holding_buffer == $past(word)))
    else $error("character not moved to holding buffer");
  AST_RX_OVR: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_done && full) |=> (ovr && $stable(rx_holding_buffer)))
    else $error("overrun not flagged");
  AST_RX_FE: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_done && !full && !maj) |=> (fe && full))
    else $error("framing error not flagged");
  AST_RX_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !rx_on_i |=> (rx_st == RX_HUNT))
    else $error("receiver active while disabled");
  AST_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    (data_rd_i && rd_armed && !status_rd_i && !rx_done) |=> (!full && !ovr))
    else $error("clear sequence failed");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    (full && rx_irq_enable_i && !cpu_irq_mask_i) |-> irq_o)
    else $error("receive interrupt missing");
  AST_IRQ_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_irq_mask_i |-> !irq_o)
    else $error("interrupt raised while masked");
  AST_IRQ_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rx_irq_enable_i && !idle_irq_enable_i) |-> !irq_o)
    else $error("interrupt raised while disabled");
  AST_IDLE_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    (idle_f && idle_irq_enable_i && !cpu_irq_mask_i) |-> irq_o)
    else $error("idle interrupt missing");
endmodule : asb_serial

// *** testbench/asb_remote.sv ***
/*
 Remote asynchronous transmitter model driving the unit's receive pin.
 Assumes clk_i is the unit clock and one bit lasts BIT_CLKS clocks times the
 multiple given to each send.
*/
`timescale 1ns/100ps
module asb_remote #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_i,
  output logic line_o
);
  // line idles high between frames
  initial line_o = 1'b1;

  task automatic send(input logic w9, input logic [8:0] d, input logic stp, input int mult);
    logic [10:0] f;
    int n;
    f = w9 ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    n = w9 ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (BIT_CLKS * mult - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    line_o <= 1'b1;
  endtask : send
endmodule : asb_remote

// *** testbench/tb.sv ***
/*
 Self-checking bench: receive, errors, clear sequence, idle, transmit, break.
 Assumes one 125 MHz clock and the remote model on the receive pin.
*/
`timescale 1ns/100ps
module tb;
  import asb_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic word9_i = 1'b0;
  logic [7:0] baud_select_reg_i = 8'h00;
  logic [7:0] extended_rx_baud_reg_i = 8'h00;
  logic tx_on_i = 1'b0;
  logic break_send_request_i = 1'b0;
  logic tx_wr_i = 1'b0;
  logic [8:0] tx_data_i = 9'h000;
  logic rx_on_i = 1'b0;
  logic status_rd_i = 1'b0;
  logic data_rd_i = 1'b0;
  logic rx_irq_enable_i = 1'b0;
  logic idle_irq_enable_i = 1'b0;
  logic cpu_irq_mask_i = 1'b0;
  logic rx_line;
  logic tx_holding_empty_o, txd_o, ninth_rx_bit_o, rx_holding_full_o, idle_flag_o;
  logic overrun_o, noise_o, framing_o, irq_o;
  logic [7:0] rx_data_o;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;

  always #4 clk_i = ~clk_i;

  asb_serial asb_serial_i (.clk_i, .rst_i, .word9_i, .baud_select_reg_i,
    .extended_rx_baud_reg_i, .tx_on_i, .break_send_request_i, .tx_wr_i, .tx_data_i,
    .tx_holding_empty_o, .txd_o, .rx_on_i, .rx_in_pin_i(rx_line), .status_rd_i,
    .data_rd_i, .rx_data_o, .ninth_rx_bit_o, .rx_holding_full_o, .idle_flag_o,
    .overrun_o, .noise_o, .framing_o, .rx_irq_enable_i, .idle_irq_enable_i,
    .cpu_irq_mask_i, .irq_o);
  asb_remote asb_remote_i (.clk_i, .line_o(rx_line));

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // run is about 2500 cycles; the ceiling leaves over four times that
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic wait_full();
    int k;
    k = 0;
    while (rx_holding_full_o !== 1'b1 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    #1;
  endtask : wait_full

  // status access first, then the data read
  task automatic clr_seq();
    @(posedge clk_i);
    status_rd_i <= 1'b1;
    @(posedge clk_i);
    status_rd_i <= 1'b0;
    data_rd_i <= 1'b1;
    @(posedge clk_i);
    data_rd_i <= 1'b0;
    settle(2);
  endtask : clr_seq

  task automatic wait_low();
    int k;
    k = 0;
    while (txd_o !== 1'b0 && k < 1000) begin
      @(posedge clk_i);
      k++;
    end
  endtask : wait_low

  // sample each transmitted bit at its centre
  task automatic get_tx(input int n, output logic [8:0] d, output int t);
    d = 9'h000;
    wait_low();
    t = cyc;
    repeat (8) @(posedge clk_i);
    chk(txd_o, 9'h000);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge clk_i);
      d[i] = txd_o;
    end
    repeat (16) @(posedge clk_i);
    chk(txd_o, 9'h001);
  endtask : get_tx

  initial begin
    int t0, t1, low;
    logic [8:0] d;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    chk({txd_o, tx_holding_empty_o}, 9'h003);
    chk({rx_holding_full_o, irq_o}, 9'h000);
    // word length and baud already set, enable last
    @(posedge clk_i);
    rx_irq_enable_i <= 1'b1;
    rx_on_i <= 1'b1;
    asb_remote_i.send(1'b0, 9'h0a5, 1'b1, 1);
    wait_full();
    chk(rx_data_o, 9'h0a5);
    chk({framing_o, noise_o, overrun_o}, 9'h000);
    chk(irq_o, 9'h001);
    @(posedge clk_i);
    cpu_irq_mask_i <= 1'b1;
    settle(2);
    chk(irq_o, 9'h000);
    settle(12 * 16);
    chk(idle_flag_o, 9'h001);
    @(posedge clk_i);
    rx_irq_enable_i <= 1'b0;
    idle_irq_enable_i <= 1'b1;
    cpu_irq_mask_i <= 1'b0;
    settle(1);
    chk(irq_o, 9'h001);
    clr_seq();
    chk({rx_holding_full_o, idle_flag_o}, 9'h000);
    chk(irq_o, 9'h000);
    @(posedge clk_i);
    word9_i <= 1'b1;
    asb_remote_i.send(1'b1, 9'h1c3, 1'b1, 1);
    wait_full();
    chk({ninth_rx_bit_o, rx_data_o}, 9'h1c3);
    // a data read without the status access leaves the flag set
    @(posedge clk_i);
    data_rd_i <= 1'b1;
    @(posedge clk_i);
    data_rd_i <= 1'b0;
    settle(2);
    chk(rx_holding_full_o, 9'h001);
    asb_remote_i.send(1'b1, 9'h055, 1'b1, 1);
    settle(8);
    chk({overrun_o, rx_data_o}, 9'h1c3);
    clr_seq();
    chk({rx_holding_full_o, overrun_o}, 9'h000);
    asb_remote_i.send(1'b1, 9'h000, 1'b0, 1);
    settle(8);
    chk(framing_o, 9'h001);
    clr_seq();
    // a nonzero extended prescaler halves the receive bit rate here
    @(posedge clk_i);
    word9_i <= 1'b0;
    extended_rx_baud_reg_i <= 8'h01;
    asb_remote_i.send(1'b0, 9'h03c, 1'b1, 2);
    wait_full();
    chk({noise_o, rx_data_o}, 9'h03c);
    clr_seq();
    // transmit: idle frame must precede the first data frame
    @(posedge clk_i);
    extended_rx_baud_reg_i <= 8'h00;
    tx_on_i <= 1'b1;
    t0 = cyc;
    @(posedge clk_i);
    tx_wr_i <= 1'b1;
    tx_data_i <= 9'h05a;
    @(posedge clk_i);
    tx_wr_i <= 1'b0;
    get_tx(8, d, t1);
    chk(9'(t1 - t0 >= 160), 9'h001);
    chk(d, 9'h05a);
    for (int w = 0; w < 2; w++) begin
      @(posedge clk_i);
      word9_i <= w[0];
      break_send_request_i <= 1'b1;
      wait_low();
      repeat (299) @(posedge clk_i);
      // in 9-bit mode a word waits behind the breaks
      tx_wr_i <= w[0];
      tx_data_i <= 9'h10f;
      @(posedge clk_i);
      tx_wr_i <= 1'b0;
      break_send_request_i <= 1'b0;
      low = 300;
      while (txd_o === 1'b0 && low < 2000) begin
        @(posedge clk_i);
        low++;
      end
      // released within the second frame, so exactly two frames go out
      chk(9'(low >= (w ? 350 : 318) && low <= (w ? 354 : 322)), 9'h001);
      repeat (8) @(posedge clk_i);
      chk(txd_o, 9'h001);
    end
    // the held word starts exactly one bit after the last break frame
    chk(tx_holding_empty_o, 9'h000);
    t0 = cyc;
    get_tx(9, d, t1);
    chk(9'(t1 - t0), 9'h008);
    chk(d, 9'h10f);
    stop_test();
  end
endmodule : tb
